// ---- verilog/pdcs_pkg.sv ----
// Package for the device control and status register block.
// Assumes one 40 MHz core clock and configuration accesses on dword addresses.
package pdcs_pkg;

    // Register placement and reset image
    localparam logic [11:0] PDCS_CSR_OFFSET = 12'h0C8;
    localparam logic [31:0] PDCS_CSR_RESET = 32'h0000_2000;
    localparam int PDCS_DW_LSB = 2;

    // Field positions
    localparam int PDCS_RSVD_LSB = 22;
    localparam int PDCS_PEND_BIT = 21;
    localparam int PDCS_AUXSEEN_BIT = 20;
    localparam int PDCS_FLAG_LSB = 16;
    localparam int PDCS_RETRY_BIT = 15;
    localparam int PDCS_MRRS_LSB = 12;
    localparam int PDCS_NOSNOOP_BIT = 11;
    localparam int PDCS_AUXUSE_BIT = 10;
    localparam int PDCS_PHANTOM_BIT = 9;
    localparam int PDCS_WIDETAG_BIT = 8;
    localparam int PDCS_PAYLOAD_LSB = 5;
    localparam int PDCS_RELAXED_BIT = 4;
    localparam int PDCS_UR_REP_BIT = 3;
    localparam int PDCS_FATAL_REP_BIT = 2;
    localparam int PDCS_NONFATAL_REP_BIT = 1;
    localparam int PDCS_COR_REP_BIT = 0;
    localparam int PDCS_NUM_FLAGS = 4;

    // Flag index inside the error-detected nibble
    localparam int PDCS_FLAG_COR = 0;
    localparam int PDCS_FLAG_NONFATAL = 1;
    localparam int PDCS_FLAG_FATAL = 2;
    localparam int PDCS_FLAG_UR = 3;

    // Byte lanes
    localparam int PDCS_LANE_LOW = 0;
    localparam int PDCS_LANE_MID = 1;
    localparam int PDCS_LANE_FLAGS = 2;

    // Field reset values and hardwired values
    localparam logic [2:0] PDCS_MRRS_RESET = 3'h2;
    localparam logic [2:0] PDCS_PAYLOAD_RESET = 3'h0;
    localparam logic [2:0] PDCS_PAYLOAD_CAP = 3'h0;
    localparam logic PDCS_BIT_ZERO = 1'b0;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pdcs_cfg_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } pdcs_cfg_rsp_type;

    typedef struct packed {
        logic unsupported;
        logic fatal;
        logic nonfatal;
        logic correctable;
    } pdcs_err_evt_type;

    typedef struct packed {
        logic retry_allow;
        logic [2:0] read_request_limit;
        logic aux_supply_use_allow;
        logic [2:0] payload_limit;
        logic unsupported_request_report;
        logic fatal_error_report;
        logic nonfatal_error_report;
        logic correctable_error_report;
    } pdcs_ctrl_type;

    typedef struct packed {
        logic err_fatal;
        logic err_nonfatal;
        logic err_cor;
    } pdcs_msg_type;

endpackage

// ---- verilog/pdcs_w1c_flag.sv ----
// One sticky error-detected flag, cleared by a write of one.
// Assumes set and clear are single-cycle qualifiers in the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module pdcs_w1c_flag
    import pdcs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);
    logic flag_reg;
    logic flag_next;

    // Set wins over a simultaneous clear
    always_comb
    begin
        flag_next = set_i | (flag_reg & ~clr_i);
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flag_reg <= PDCS_BIT_ZERO;
        else if (clk_en_i)
            flag_reg <= flag_next;
    end

    assign flag_o = flag_reg;
endmodule
`default_nettype wire

// ---- verilog/pdcs_err_gate.sv ----
// Error message gating from detected events and reporting enables.
// Assumes the message sender takes a one-cycle request pulse.
`timescale 1ns/10ps
`default_nettype none
module pdcs_err_gate
    import pdcs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // Causes
    input wire pdcs_err_evt_type evt_i,
    input wire pdcs_ctrl_type ctrl_i,
    input wire logic sys_err_allow_i,
    // Requests
    output pdcs_msg_type msg_o
);
    pdcs_msg_type msg_reg;
    pdcs_msg_type msg_next;

    always_comb
    begin
        msg_next.err_cor = evt_i.correctable & ctrl_i.correctable_error_report;
        msg_next.err_nonfatal = (evt_i.nonfatal & (ctrl_i.nonfatal_error_report
            | sys_err_allow_i)) | (evt_i.unsupported & ctrl_i.unsupported_request_report
            & (ctrl_i.nonfatal_error_report | sys_err_allow_i));
        msg_next.err_fatal = evt_i.fatal & (ctrl_i.fatal_error_report
            | sys_err_allow_i);
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            msg_reg <= '0;
        else if (clk_en_i)
            msg_reg <= msg_next;
    end

    assign msg_o = msg_reg;
endmodule
`default_nettype wire

// ---- verilog/pdcs_csr.sv ----
// Device control and status register of the PCIe capability structure.
// Assumes configuration requests arrive synchronous to sys_clk_i, one per cycle at most.
`timescale 1ns/10ps
`default_nettype none
module pdcs_csr
    import pdcs_pkg::*;
(
    // Clock, enable and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // Configuration access from the upstream side
    input wire pdcs_cfg_req_type cfg_req_i,
    output pdcs_cfg_rsp_type cfg_rsp_o,
    // Bridge status inputs
    input wire pdcs_err_evt_type err_evt_i,
    input wire logic nonposted_outstanding_i,
    input wire logic aux_supply_seen_i,
    input wire logic sys_err_allow_i,
    // Control towards the bridge
    output pdcs_ctrl_type ctrl_o,
    output logic [2:0] payload_effective_o,
    output pdcs_msg_type msg_o
);

    // Decoding used by both read and write paths
    function automatic logic csr_hit(input logic [11:0] addr);
        csr_hit = (addr[11:PDCS_DW_LSB] == PDCS_CSR_OFFSET[11:PDCS_DW_LSB]);
    endfunction

    function automatic logic lane_written(input pdcs_cfg_req_type req, input int lane);
        lane_written = req.valid & req.write & csr_hit(req.addr) & req.be[lane];
    endfunction

    logic wr_low;
    logic wr_mid;
    logic wr_flags;
    pdcs_ctrl_type ctrl_reg;
    pdcs_ctrl_type ctrl_next;
    logic pend_reg;
    logic aux_seen_reg;
    logic [PDCS_NUM_FLAGS-1:0] flag_set;
    logic [PDCS_NUM_FLAGS-1:0] flag_clr;
    logic [PDCS_NUM_FLAGS-1:0] flag_vec;
    logic [31:0] csr_image;
    pdcs_cfg_rsp_type rsp_reg;
    pdcs_cfg_rsp_type rsp_next;
    logic [2:0] payload_eff_reg;

    assign wr_low = lane_written(cfg_req_i, PDCS_LANE_LOW);
    assign wr_mid = lane_written(cfg_req_i, PDCS_LANE_MID);
    assign wr_flags = lane_written(cfg_req_i, PDCS_LANE_FLAGS);

    // Writable control fields; lane 3 holds only reserved bits
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_mid)
        begin
            ctrl_next.retry_allow = cfg_req_i.wdata[PDCS_RETRY_BIT];
            ctrl_next.read_request_limit =
                cfg_req_i.wdata[PDCS_MRRS_LSB +: 3];
            ctrl_next.aux_supply_use_allow = cfg_req_i.wdata[PDCS_AUXUSE_BIT];
        end
        if (wr_low)
        begin
            ctrl_next.payload_limit = cfg_req_i.wdata[PDCS_PAYLOAD_LSB +: 3];
            ctrl_next.unsupported_request_report =
                cfg_req_i.wdata[PDCS_UR_REP_BIT];
            ctrl_next.fatal_error_report = cfg_req_i.wdata[PDCS_FATAL_REP_BIT];
            ctrl_next.nonfatal_error_report =
                cfg_req_i.wdata[PDCS_NONFATAL_REP_BIT];
            ctrl_next.correctable_error_report =
                cfg_req_i.wdata[PDCS_COR_REP_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_reg <= '0;
            ctrl_reg.read_request_limit <= PDCS_MRRS_RESET;
            ctrl_reg.payload_limit <= PDCS_PAYLOAD_RESET;
        end
        else if (clk_en_i)
            ctrl_reg <= ctrl_next;
    end

    // Live status sampled each cycle that clk_en_i is high
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pend_reg <= PDCS_BIT_ZERO;
            aux_seen_reg <= PDCS_BIT_ZERO;
        end
        else if (clk_en_i)
        begin
            pend_reg <= nonposted_outstanding_i;
            aux_seen_reg <= aux_supply_seen_i;
        end
    end

    // Flags set on events whatever the reporting enables say
    assign flag_set[PDCS_FLAG_UR] = err_evt_i.unsupported;
    assign flag_set[PDCS_FLAG_FATAL] = err_evt_i.fatal;
    assign flag_set[PDCS_FLAG_NONFATAL] = err_evt_i.nonfatal;
    assign flag_set[PDCS_FLAG_COR] = err_evt_i.correctable;

    generate
        for (genvar i = 0; i < PDCS_NUM_FLAGS; i++)
        begin : g_flag
            assign flag_clr[i] = wr_flags & cfg_req_i.wdata[PDCS_FLAG_LSB + i];
            pdcs_w1c_flag u_flag (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .clk_en_i(clk_en_i),
                .set_i(flag_set[i]),
                .clr_i(flag_clr[i]),
                .flag_o(flag_vec[i])
            );
        end
    endgenerate

    // Read image; hardwired bits stay zero
    always_comb
    begin
        csr_image = '0;
        csr_image[PDCS_PEND_BIT] = pend_reg;
        csr_image[PDCS_AUXSEEN_BIT] = aux_seen_reg;
        csr_image[PDCS_FLAG_LSB +: PDCS_NUM_FLAGS] = flag_vec;
        csr_image[PDCS_RETRY_BIT] = ctrl_reg.retry_allow;
        csr_image[PDCS_MRRS_LSB +: 3] = ctrl_reg.read_request_limit;
        csr_image[PDCS_NOSNOOP_BIT] = PDCS_BIT_ZERO;
        csr_image[PDCS_AUXUSE_BIT] = ctrl_reg.aux_supply_use_allow;
        csr_image[PDCS_PHANTOM_BIT] = PDCS_BIT_ZERO;
        csr_image[PDCS_WIDETAG_BIT] = PDCS_BIT_ZERO;
        csr_image[PDCS_PAYLOAD_LSB +: 3] = ctrl_reg.payload_limit;
        csr_image[PDCS_RELAXED_BIT] = PDCS_BIT_ZERO;
        csr_image[PDCS_UR_REP_BIT] = ctrl_reg.unsupported_request_report;
        csr_image[PDCS_FATAL_REP_BIT] = ctrl_reg.fatal_error_report;
        csr_image[PDCS_NONFATAL_REP_BIT] = ctrl_reg.nonfatal_error_report;
        csr_image[PDCS_COR_REP_BIT] = ctrl_reg.correctable_error_report;
    end

    // Every request with clk_en_i high acknowledged next cycle; other offsets read zero
    always_comb
    begin
        rsp_next.ack = cfg_req_i.valid;
        rsp_next.rdata = '0;
        if (cfg_req_i.valid && !cfg_req_i.write && csr_hit(cfg_req_i.addr))
            rsp_next.rdata = csr_image;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rsp_reg <= '0;
        else if (clk_en_i)
            rsp_reg <= rsp_next;
    end

    // Payload in use never exceeds the supported capability
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            payload_eff_reg <= PDCS_PAYLOAD_CAP;
        else if (clk_en_i)
            payload_eff_reg <= PDCS_PAYLOAD_CAP;
    end

    pdcs_err_gate u_gate (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .evt_i(err_evt_i),
        .ctrl_i(ctrl_reg),
        .sys_err_allow_i(sys_err_allow_i),
        .msg_o(msg_o)
    );

    assign cfg_rsp_o = rsp_reg;
    assign ctrl_o = ctrl_reg;
    assign payload_effective_o = payload_eff_reg;

    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic past_valid_reg;
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            past_valid_reg <= PDCS_BIT_ZERO;
        else
            past_valid_reg <= 1'b1;
    end

    a_reset_image: assert property (!past_valid_reg |-> csr_image == PDCS_CSR_RESET)
        else $error("register image differs from reset value");

    a_read_returns: assert property (clk_en_i && cfg_req_i.valid && !cfg_req_i.write
        && csr_hit(cfg_req_i.addr) |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == $past(csr_image))
        else $error("read of register returned wrong data");

    a_unmapped_zero: assert property (clk_en_i && cfg_req_i.valid
        && !csr_hit(cfg_req_i.addr) |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == '0)
        else $error("unmapped offset returned data");

    a_reserved_zero: assert property (cfg_rsp_o.rdata[31:PDCS_RSVD_LSB] == '0)
        else $error("reserved bits read nonzero");

    a_pending_tracks: assert property (clk_en_i |=> csr_image[PDCS_PEND_BIT]
        == $past(nonposted_outstanding_i))
        else $error("pending bit does not follow outstanding requests");

    a_aux_tracks: assert property (clk_en_i |=> csr_image[PDCS_AUXSEEN_BIT]
        == $past(aux_supply_seen_i))
        else $error("aux detected bit does not follow input");

    a_ur_sets: assert property (clk_en_i && err_evt_i.unsupported
        |=> flag_vec[PDCS_FLAG_UR])
        else $error("unsupported request flag not set");

    a_ur_clear: assert property (clk_en_i && flag_clr[PDCS_FLAG_UR]
        && !err_evt_i.unsupported |=> !flag_vec[PDCS_FLAG_UR])
        else $error("unsupported request flag not cleared by write of one");

    a_fatal_sticks: assert property (flag_vec[PDCS_FLAG_FATAL] && !(clk_en_i
        && flag_clr[PDCS_FLAG_FATAL]) |=> flag_vec[PDCS_FLAG_FATAL])
        else $error("fatal flag dropped without clear");

    a_fatal_sets: assert property (clk_en_i && err_evt_i.fatal
        |=> flag_vec[PDCS_FLAG_FATAL])
        else $error("fatal flag not set");

    a_nonfatal_clear: assert property (clk_en_i && flag_clr[PDCS_FLAG_NONFATAL]
        && !err_evt_i.nonfatal |=> !flag_vec[PDCS_FLAG_NONFATAL])
        else $error("nonfatal flag not cleared by write of one");

    a_nonfatal_sets: assert property (clk_en_i && err_evt_i.nonfatal
        |=> flag_vec[PDCS_FLAG_NONFATAL])
        else $error("nonfatal flag not set");

    a_cor_sets: assert property (clk_en_i && err_evt_i.correctable
        |=> flag_vec[PDCS_FLAG_COR])
        else $error("correctable flag not set");

    a_cor_clear: assert property (clk_en_i && flag_clr[PDCS_FLAG_COR]
        && !err_evt_i.correctable |=> !flag_vec[PDCS_FLAG_COR])
        else $error("correctable flag not cleared by write of one");

    a_flags_frozen: assert property (!clk_en_i |=> $stable(flag_vec) && $stable(ctrl_reg))
        else $error("state moved while clock enable low");

    a_retry_write: assert property (clk_en_i && wr_mid |=> ctrl_reg.retry_allow
        == $past(cfg_req_i.wdata[PDCS_RETRY_BIT]))
        else $error("retry enable not written");

    a_mrrs_write: assert property (clk_en_i && wr_mid |=> ctrl_reg.read_request_limit
        == $past(cfg_req_i.wdata[PDCS_MRRS_LSB +: 3]))
        else $error("read request limit not written");

    a_hardwired_zero: assert property (
        csr_image[PDCS_NOSNOOP_BIT] == 1'b0 && csr_image[PDCS_PHANTOM_BIT] == 1'b0
        && csr_image[PDCS_WIDETAG_BIT] == 1'b0 && csr_image[PDCS_RELAXED_BIT] == 1'b0)
        else $error("hardwired bit reads one");

    a_auxuse_write: assert property (clk_en_i && wr_mid |=> ctrl_reg.aux_supply_use_allow
        == $past(cfg_req_i.wdata[PDCS_AUXUSE_BIT]))
        else $error("aux power use enable not written");

    a_payload_write: assert property (clk_en_i && wr_low |=> ctrl_reg.payload_limit
        == $past(cfg_req_i.wdata[PDCS_PAYLOAD_LSB +: 3]))
        else $error("payload field not written");

    a_report_write: assert property (clk_en_i && wr_low |=>
        {ctrl_reg.unsupported_request_report, ctrl_reg.fatal_error_report,
        ctrl_reg.nonfatal_error_report, ctrl_reg.correctable_error_report}
        == $past(cfg_req_i.wdata[PDCS_COR_REP_BIT +: PDCS_NUM_FLAGS]))
        else $error("reporting enables not written");

    a_payload_cap: assert property (payload_effective_o == PDCS_PAYLOAD_CAP)
        else $error("effective payload exceeds capability");

    a_fatal_msg: assert property (clk_en_i && err_evt_i.fatal
        && !ctrl_reg.fatal_error_report && !sys_err_allow_i |=> !msg_o.err_fatal)
        else $error("fatal message sent while reporting disabled");

    a_fatal_msg_on: assert property (clk_en_i && err_evt_i.fatal
        && ctrl_reg.fatal_error_report |=> msg_o.err_fatal)
        else $error("fatal message missing");

    a_nonfatal_msg: assert property (clk_en_i && err_evt_i.nonfatal
        && ctrl_reg.nonfatal_error_report |=> msg_o.err_nonfatal)
        else $error("nonfatal message missing");

    a_ur_msg: assert property (clk_en_i && err_evt_i.unsupported && !err_evt_i.nonfatal
        && !ctrl_reg.unsupported_request_report |=> !msg_o.err_nonfatal)
        else $error("unsupported request reported while disabled");

    a_cor_msg: assert property (clk_en_i && err_evt_i.correctable
        && ctrl_reg.correctable_error_report |=> msg_o.err_cor)
        else $error("correctable message missing");

    a_cor_msg_off: assert property (clk_en_i && err_evt_i.correctable
        && !ctrl_reg.correctable_error_report |=> !msg_o.err_cor)
        else $error("correctable message sent while reporting disabled");

    c_flag_clear: cover property (flag_vec[PDCS_FLAG_UR] ##1 clk_en_i
        && flag_clr[PDCS_FLAG_UR] ##1 !flag_vec[PDCS_FLAG_UR]);
    c_set_beats_clear: cover property (clk_en_i && err_evt_i.fatal
        && flag_clr[PDCS_FLAG_FATAL]);
    c_read_access: cover property (cfg_rsp_o.ack && cfg_rsp_o.rdata != '0);
    c_fatal_msg: cover property (msg_o.err_fatal);
    c_frozen_event: cover property (!clk_en_i && err_evt_i.fatal);

endmodule
`default_nettype wire

// ---- test/pdcs_rc_model.sv ----
// Upstream requester model: issues configuration reads and writes.
// Assumes the register block answers each request with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module pdcs_rc_model
    import pdcs_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Configuration bus
    output var pdcs_cfg_req_type cfg_req_o,
    input wire pdcs_cfg_rsp_type cfg_rsp_i
);
    initial cfg_req_o = '0;

    // One request after gap idle cycles, then a bounded wait for the ack
    task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
        input logic [31:0] wdata, input int gap, output logic [31:0] rdata, output logic ok);
        int n;
        repeat (gap) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        cfg_req_o <= '{1'b1, wr, addr, be, wdata};
        @(posedge sys_clk_i);
        // Released bus shows no stale request
        cfg_req_o <= '{1'b0, ~wr, ~addr, ~be, ~wdata};
        ok = 1'b0;
        rdata = 32'h0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (cfg_rsp_i.ack === 1'b1)
            begin
                ok = 1'b1;
                rdata = cfg_rsp_i.rdata;
            end
            else
                @(posedge sys_clk_i);
        end
    endtask
endmodule
`default_nettype wire

// ---- test/tb_pdcs_csr.sv ----
// Self-checking bench for the device control and status register.
// Assumes the block answers at a fixed offset with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module tb_pdcs_csr
    import pdcs_pkg::*;
;
    typedef struct packed {
        logic [3:0] be;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } pdcs_row_type;

    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    pdcs_cfg_req_type cfg_req_i;
    pdcs_cfg_rsp_type cfg_rsp_o;
    pdcs_err_evt_type err_evt_i = '0;
    logic nonposted_outstanding_i = 1'b0;
    logic aux_supply_seen_i = 1'b0;
    logic sys_err_allow_i = 1'b0;
    pdcs_ctrl_type ctrl_o;
    logic [2:0] payload_effective_o;
    pdcs_msg_type msg_o;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] rd_val;
    logic [2:0] msg_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h2};
    pdcs_row_type rows [6] = '{
        '{4'hF, 32'hFFFF_FFFF, 32'h0000_F4EF},
        '{4'h1, 32'h0000_0000, 32'h0000_F400},
        '{4'h2, 32'h0000_2A00, 32'h0000_2000},
        '{4'h8, 32'hFFFF_FFFF, 32'h0000_2000},
        '{4'h3, 32'h0000_6F0E, 32'h0000_640E},
        '{4'hF, 32'h0000_10A0, 32'h0000_10A0}};

    always #12.5 sys_clk_i = ~sys_clk_i;

    pdcs_csr u_pdcs_csr (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .cfg_req_i(cfg_req_i),
        .cfg_rsp_o(cfg_rsp_o),
        .err_evt_i(err_evt_i),
        .nonposted_outstanding_i(nonposted_outstanding_i),
        .aux_supply_seen_i(aux_supply_seen_i),
        .sys_err_allow_i(sys_err_allow_i),
        .ctrl_o(ctrl_o),
        .payload_effective_o(payload_effective_o),
        .msg_o(msg_o)
    );

    pdcs_rc_model u_pdcs_rc_model (
        .sys_clk_i(sys_clk_i),
        .cfg_req_o(cfg_req_i),
        .cfg_rsp_i(cfg_rsp_o)
    );

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
        input logic [31:0] wdata, input int gap);
        logic ok;
        u_pdcs_rc_model.access(wr, addr, be, wdata, gap, rd_val, ok);
        if (!ok)
        begin
            fail_count++;
            $display("Error ack expected 1 seen 0");
            final_report();
        end
    endtask

    task automatic rd_check(input string what, input logic [11:0] addr, input logic [31:0] exp);
        access(1'b0, addr, 4'h0, 32'h0, 0);
        check(what, exp, rd_val);
    endtask

    // Expected control outputs from a register image
    function automatic logic [31:0] ctrl_of(input logic [31:0] v);
        pdcs_ctrl_type c;
        c = '{v[15], v[14:12], v[10], v[7:5], v[3], v[2], v[1], v[0]};
        return {20'h0, c};
    endfunction

    task automatic pulse(input int i, input logic [2:0] mexp);
        @(posedge sys_clk_i);
        err_evt_i <= pdcs_err_evt_type'(4'h1 << i);
        @(posedge sys_clk_i);
        err_evt_i <= '0;
        #1;
        check("msg_o", {29'h0, mexp}, {29'h0, msg_o});
        @(posedge sys_clk_i);
        #1;
        check("msg_o fall", 32'h0, {29'h0, msg_o});
    endtask

    task automatic do_reset();
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd_check("reset image", 12'h0C8, 32'h0000_2000);
        check("reset ctrl_o", ctrl_of(32'h0000_2000), {20'h0, ctrl_o});
    endtask

    initial
    begin
        int i;
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd_check("reset image", 12'h0C8, 32'h0000_2000);
        check("payload_effective_o", 32'h0, {29'h0, payload_effective_o});
        // Status inputs appear in the image
        @(posedge sys_clk_i);
        nonposted_outstanding_i <= 1'b1;
        rd_check("pending bit", 12'h0C8, 32'h0020_2000);
        @(posedge sys_clk_i);
        nonposted_outstanding_i <= 1'b0;
        aux_supply_seen_i <= 1'b1;
        rd_check("aux seen bit", 12'h0C8, 32'h0010_2000);
        @(posedge sys_clk_i);
        aux_supply_seen_i <= 1'b0;
        // Table of writes, each read back with the control outputs
        for (i = 0; i < 6; i++)
        begin
            access(1'b1, 12'h0C8, rows[i].be, rows[i].wdata, i % 2);
            rd_check("row image", 12'h0C8, rows[i].rexp);
            check("row ctrl_o", ctrl_of(rows[i].rexp), {20'h0, ctrl_o});
            check("row payload_effective_o", 32'h0, {29'h0, payload_effective_o});
        end
        // Unmapped offset reads zero and leaves the register alone
        access(1'b1, 12'h0CC, 4'hF, 32'hFFFF_FFFF, 0);
        rd_check("unmapped", 12'h0CC, 32'h0000_0000);
        rd_check("low address bits", 12'h0CB, 32'h0000_10A0);
        // Each flag with its report enable set
        access(1'b1, 12'h0C8, 4'hF, 32'h0000_000F, 0);
        for (i = 0; i < 4; i++)
        begin
            pulse(i, msg_exp[i]);
            rd_check("flag set", 12'h0C8, 32'h0000_000F | (32'h1 << (16 + i)));
            access(1'b1, 12'h0C8, 4'h4, 32'h0000_0000, 0);
            rd_check("flag after write 0", 12'h0C8, 32'h0000_000F | (32'h1 << (16 + i)));
            access(1'b1, 12'h0C8, 4'h4, 32'h000F_0000, 1);
            rd_check("flag after write 1", 12'h0C8, 32'h0000_000F);
        end
        // Clock enable low: an event leaves no flag and no message
        @(posedge sys_clk_i);
        clk_en_i <= 1'b0;
        pulse(PDCS_FLAG_FATAL, 3'h0);
        @(posedge sys_clk_i);
        clk_en_i <= 1'b1;
        rd_check("frozen event", 12'h0C8, 32'h0000_000F);
        // Event and write-one clear in one cycle: the event wins
        fork
            access(1'b1, 12'h0C8, 4'h4, 32'h0004_0000, 0);
            begin
                @(posedge sys_clk_i);
                err_evt_i <= pdcs_err_evt_type'(4'h4);
                @(posedge sys_clk_i);
                err_evt_i <= '0;
            end
        join
        rd_check("set beats clear", 12'h0C8, 32'h0004_000F);
        // Reports disabled: flags still set, messages only via the other enable
        access(1'b1, 12'h0C8, 4'h1, 32'h0000_0002, 0);
        pulse(PDCS_FLAG_UR, 3'h0);
        access(1'b1, 12'h0C8, 4'hF, 32'h0000_0000, 0);
        @(posedge sys_clk_i);
        sys_err_allow_i <= 1'b1;
        pulse(PDCS_FLAG_FATAL, 3'h4);
        pulse(PDCS_FLAG_COR, 3'h0);
        @(posedge sys_clk_i);
        sys_err_allow_i <= 1'b0;
        pulse(PDCS_FLAG_NONFATAL, 3'h0);
        rd_check("flags without reports", 12'h0C8, 32'h000F_0000);
        check("ctrl_o cleared", 32'h0, {20'h0, ctrl_o});
        // Second reset in mid-run
        access(1'b1, 12'h0C8, 4'hF, 32'h0000_FFFF, 0);
        do_reset();
        rd_check("after reset", 12'h0C8, 32'h0000_2000);
        final_report();
    end
endmodule
`default_nettype wire
